/* verilog/system_clock_control_regs.sv */
// System clock control registers with wait and stop mode sequencing
`timescale 1ns/1ps

module system_clock_control_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire clock_ctrl_pkg::bus_req_s bus_req,
  output logic [7:0] rdata,
  input wire logic wake_irq,
  output clock_ctrl_pkg::clk_out_s clk_out
);

  clock_ctrl_pkg::ctrl_state_s s_reg;
  clock_ctrl_pkg::ctrl_state_s s_next;
  logic [2:0] div_code;
  logic crystal_osc_en;
  logic feedback_res_en;
  logic osc_pins_port;
  logic low_speed_osc_en;
  logic write_ok;
  logic wr_cm0;
  logic wr_cm1;
  logic wr_cm3;
  logic wr_protect;
  logic wr_src_sel;
  logic [7:0] cm1_wval;

  // ****************************************************************
  // Decoders of the registered control bits
  // ****************************************************************
  cpu_div_decode u_div (
    .div8_select(s_reg.cm0[clock_ctrl_pkg::DIV8_SELECT_BIT]),
    .cpu_div(s_reg.cm1[clock_ctrl_pkg::CPU_DIV_HI_BIT:clock_ctrl_pkg::CPU_DIV_LO_BIT]),
    .div_code(div_code)
  );

  osc_pin_decode u_osc (
    .crystal_stop(s_reg.cm0[clock_ctrl_pkg::CRYSTAL_STOP_BIT]),
    .feedback_resistor_off(s_reg.cm1[clock_ctrl_pkg::FEEDBACK_OFF_BIT]),
    .all_clock_stop(s_reg.cm1[clock_ctrl_pkg::ALL_CLOCK_STOP_BIT]),
    .osc_pin_assign(s_reg.cm1[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT]),
    .low_speed_osc_off(s_reg.cm1[clock_ctrl_pkg::LOW_SPEED_OFF_BIT]),
    .crystal_osc_en(crystal_osc_en),
    .feedback_res_en(feedback_res_en),
    .osc_pins_port(osc_pins_port),
    .low_speed_osc_en(low_speed_osc_en)
  );

  // ****************************************************************
  // Write decode; the protect bit gates registers 0, 1 and source select
  // ****************************************************************
  assign write_ok = s_reg.protect[clock_ctrl_pkg::CLOCK_WRITE_ENABLE_BIT];
  assign wr_cm0 = bus_req.wr && bus_req.addr == clock_ctrl_pkg::CM0_ADDR && write_ok;
  assign wr_cm1 = bus_req.wr && bus_req.addr == clock_ctrl_pkg::CM1_ADDR && write_ok;
  assign wr_cm3 = bus_req.wr && bus_req.addr == clock_ctrl_pkg::CM3_ADDR;
  assign wr_protect = bus_req.wr && bus_req.addr == clock_ctrl_pkg::PROTECT_ADDR;
  assign wr_src_sel = bus_req.wr && bus_req.addr == clock_ctrl_pkg::SRC_SEL_ADDR && write_ok;

  // Pin assignment is sticky once set; low-speed off refused on oscillator clock
  always_comb begin
    cm1_wval = bus_req.wdata;
    cm1_wval[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT] = bus_req.wdata[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT]
      || s_reg.cm1[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT];
    cm1_wval[clock_ctrl_pkg::LOW_SPEED_OFF_BIT] = bus_req.wdata[clock_ctrl_pkg::LOW_SPEED_OFF_BIT]
      && !s_reg.src_sel;
  end

  // ****************************************************************
  // Next state: register writes, mode sequencing, reads, outputs
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.rdata = 8'h00;
    if (wr_cm0) begin
      s_next.cm0 = bus_req.wdata;
    end
    if (wr_cm1) begin
      s_next.cm1 = cm1_wval;
    end
    if (wr_cm3) begin
      s_next.cm3 = bus_req.wdata & clock_ctrl_pkg::CM3_WRITE_MASK;
    end
    if (wr_protect) begin
      s_next.protect = bus_req.wdata & clock_ctrl_pkg::PROTECT_WRITE_MASK;
    end
    if (wr_src_sel) begin
      s_next.src_sel = bus_req.wdata[clock_ctrl_pkg::SOURCE_SEL_BIT];
    end
    // Mode sequencing; writes during wait or stop cannot come from a halted CPU
    case (s_reg.mode)
      clock_ctrl_pkg::MODE_RUN: begin
        if (s_next.cm1[clock_ctrl_pkg::ALL_CLOCK_STOP_BIT]) begin
          s_next.cm0[clock_ctrl_pkg::DIV8_SELECT_BIT] = 1'b1;
          s_next.mode = clock_ctrl_pkg::MODE_STOP;
        end else if (s_next.cm3[clock_ctrl_pkg::WAIT_CONTROL_BIT]) begin
          if (s_next.cm3[clock_ctrl_pkg::NO_DIVISION_BIT]) begin
            s_next.cm0[clock_ctrl_pkg::DIV8_SELECT_BIT] = 1'b0;
            s_next.cm1[clock_ctrl_pkg::CPU_DIV_HI_BIT:clock_ctrl_pkg::CPU_DIV_LO_BIT] =
              clock_ctrl_pkg::CPU_DIV_NONE;
          end
          s_next.mode = clock_ctrl_pkg::MODE_WAIT;
        end
      end
      clock_ctrl_pkg::MODE_WAIT: begin
        if (wake_irq) begin
          s_next.cm3[clock_ctrl_pkg::WAIT_CONTROL_BIT] = 1'b0;
          s_next.mode = clock_ctrl_pkg::MODE_RUN;
        end
      end
      clock_ctrl_pkg::MODE_STOP: begin
        if (wake_irq) begin
          s_next.cm1[clock_ctrl_pkg::ALL_CLOCK_STOP_BIT] = 1'b0;
          s_next.mode = clock_ctrl_pkg::MODE_RUN;
        end
      end
      default: begin
        s_next.mode = clock_ctrl_pkg::MODE_RUN;
      end
    endcase
    // Crystal exit encoding starts the crystal and switches over to it
    if (s_reg.mode != clock_ctrl_pkg::MODE_RUN && wake_irq
        && s_reg.cm3[clock_ctrl_pkg::EXIT_SEL_HI_BIT:clock_ctrl_pkg::EXIT_SEL_LO_BIT]
        == clock_ctrl_pkg::EXIT_CRYSTAL) begin
      s_next.cm0[clock_ctrl_pkg::CRYSTAL_STOP_BIT] = 1'b0;
      s_next.cm1[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT] = 1'b1;
      s_next.src_sel = 1'b0;
    end
    // Oscillator as system clock always forces the low-speed off bit clear
    if (s_next.src_sel) begin
      s_next.cm1[clock_ctrl_pkg::LOW_SPEED_OFF_BIT] = 1'b0;
    end
    // Read data stands only in the cycle after the strobe
    if (bus_req.rd) begin
      case (bus_req.addr)
        clock_ctrl_pkg::CM0_ADDR: s_next.rdata = s_reg.cm0;
        clock_ctrl_pkg::CM1_ADDR: s_next.rdata = s_reg.cm1;
        clock_ctrl_pkg::CM3_ADDR: s_next.rdata = s_reg.cm3 & clock_ctrl_pkg::CM3_WRITE_MASK;
        clock_ctrl_pkg::PROTECT_ADDR: s_next.rdata = s_reg.protect;
        clock_ctrl_pkg::SRC_SEL_ADDR: s_next.rdata = {5'h00, s_reg.src_sel, 2'h0};
        default: s_next.rdata = 8'h00;
      endcase
    end
    // Outputs follow the control registers one cycle later
    s_next.outs.cpu_div_code = div_code;
    s_next.outs.cpu_clock_stop = s_reg.mode != clock_ctrl_pkg::MODE_RUN;
    s_next.outs.periph_div_stop = s_reg.mode == clock_ctrl_pkg::MODE_STOP
      || (s_reg.mode == clock_ctrl_pkg::MODE_WAIT
      && s_reg.cm0[clock_ctrl_pkg::WAIT_STOP_HI_BIT:clock_ctrl_pkg::WAIT_STOP_LO_BIT]
      != clock_ctrl_pkg::WAIT_PERIPH_RUN);
    s_next.outs.all_clocks_stop = s_reg.mode == clock_ctrl_pkg::MODE_STOP;
    s_next.outs.crystal_osc_en = crystal_osc_en;
    s_next.outs.feedback_res_en = feedback_res_en;
    s_next.outs.osc_pins_port = osc_pins_port;
    s_next.outs.low_speed_osc_en = low_speed_osc_en;
    s_next.outs.sys_clk_from_osc = s_reg.src_sel;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg.mode <= clock_ctrl_pkg::MODE_RUN;
      s_reg.cm0 <= clock_ctrl_pkg::CM0_RESET;
      s_reg.cm1 <= clock_ctrl_pkg::CM1_RESET;
      s_reg.cm3 <= clock_ctrl_pkg::CM3_RESET;
      s_reg.protect <= clock_ctrl_pkg::PROTECT_RESET;
      s_reg.src_sel <= clock_ctrl_pkg::SOURCE_SEL_RESET;
      s_reg.rdata <= 8'h00;
      s_reg.outs.cpu_div_code <= clock_ctrl_pkg::DIV_CODE_1;
      s_reg.outs.cpu_clock_stop <= 1'b0;
      s_reg.outs.periph_div_stop <= 1'b0;
      s_reg.outs.all_clocks_stop <= 1'b0;
      s_reg.outs.crystal_osc_en <= 1'b0;
      s_reg.outs.feedback_res_en <= 1'b1;
      s_reg.outs.osc_pins_port <= 1'b1;
      s_reg.outs.low_speed_osc_en <= 1'b1;
      s_reg.outs.sys_clk_from_osc <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign clk_out = s_reg.outs;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  periph_stop_wait_a: assert property (
    s_reg.mode == clock_ctrl_pkg::MODE_WAIT |=> clk_out.periph_div_stop ==
      ($past(s_reg.cm0[clock_ctrl_pkg::WAIT_STOP_HI_BIT:clock_ctrl_pkg::WAIT_STOP_LO_BIT]) != 2'h0))
    else $error("peripheral stop in wait does not follow the wait field");

  crystal_stop_out_a: assert property (
    wr_cm0 && s_reg.mode == clock_ctrl_pkg::MODE_RUN && !wr_cm1 && !s_reg.cm1[0]
      |=> ##1 clk_out.crystal_osc_en == !$past(bus_req.wdata[clock_ctrl_pkg::CRYSTAL_STOP_BIT], 2))
    else $error("crystal enable does not follow the written stop bit");

  div_code_a: assert property (
    s_reg.cm0[clock_ctrl_pkg::DIV8_SELECT_BIT] |=> clk_out.cpu_div_code == clock_ctrl_pkg::DIV_CODE_8)
    else $error("divide-by-8 select not reflected in CPU divider");

  stop_div8_a: assert property (
    $rose(s_reg.mode == clock_ctrl_pkg::MODE_STOP) |-> s_reg.cm0[clock_ctrl_pkg::DIV8_SELECT_BIT])
    else $error("stop entry did not force divide-by-8");

  protect_block_a: assert property (
    bus_req.wr && bus_req.addr == clock_ctrl_pkg::CM0_ADDR && !write_ok
      && s_reg.mode == clock_ctrl_pkg::MODE_RUN && !s_next.cm1[0] && !s_next.cm3[0] |=> $stable(s_reg.cm0))
    else $error("protected write changed register 0");

  stop_resistor_a: assert property (
    s_reg.mode == clock_ctrl_pkg::MODE_STOP ##1 s_reg.mode == clock_ctrl_pkg::MODE_STOP
      |-> !clk_out.feedback_res_en && clk_out.all_clocks_stop)
    else $error("feedback resistor connected in stop mode");

  pin_sticky_a: assert property (
    s_reg.cm1[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT] |=> s_reg.cm1[clock_ctrl_pkg::OSC_PIN_ASSIGN_BIT])
    else $error("pin assignment returned to port use");

  lso_hold_a: assert property (
    s_reg.src_sel |-> !s_reg.cm1[clock_ctrl_pkg::LOW_SPEED_OFF_BIT])
    else $error("low-speed oscillator off while it is the system clock");

  wait_exit_a: assert property (
    s_reg.mode == clock_ctrl_pkg::MODE_WAIT && wake_irq
      |=> !s_reg.cm3[clock_ctrl_pkg::WAIT_CONTROL_BIT] ##1 !clk_out.cpu_clock_stop)
    else $error("interrupt did not end wait mode");

  no_div_entry_a: assert property (
    $rose(s_reg.mode == clock_ctrl_pkg::MODE_WAIT) && s_reg.cm3[clock_ctrl_pkg::NO_DIVISION_BIT]
      |-> ##1 clk_out.cpu_div_code == clock_ctrl_pkg::DIV_CODE_1)
    else $error("no-division wait entry left a divider set");

  exit_crystal_a: assert property (
    s_reg.mode != clock_ctrl_pkg::MODE_RUN && wake_irq && s_reg.cm3[7:6] == clock_ctrl_pkg::EXIT_CRYSTAL
      |=> !s_reg.src_sel && !s_reg.cm0[clock_ctrl_pkg::CRYSTAL_STOP_BIT] ##1 clk_out.crystal_osc_en)
    else $error("crystal exit did not restart and select the crystal");

  reserved_read_a: assert property (
    bus_req.rd && bus_req.addr == clock_ctrl_pkg::CM3_ADDR |=> !rdata[1])
    else $error("register 3 bit 1 read back as one");

  read_one_cycle_a: assert property (
    !bus_req.rd |=> rdata == 8'h00)
    else $error("read data present without a read");

  wait_entry_c: cover property ($rose(s_reg.mode == clock_ctrl_pkg::MODE_WAIT));
  stop_entry_c: cover property ($rose(s_reg.mode == clock_ctrl_pkg::MODE_STOP));
  crystal_exit_c: cover property (s_reg.mode != clock_ctrl_pkg::MODE_RUN && wake_irq && s_reg.cm3[7:6] == 2'h3);
  refused_write_c: cover property (bus_req.wr && bus_req.addr == clock_ctrl_pkg::CM1_ADDR && !write_ok);

endmodule // system_clock_control_regs

/* shared/clock_ctrl_pkg.sv */
// Shared constants, types and state layout for the system clock control block
package clock_ctrl_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] CM0_INDEX = 8'h06;
  localparam logic [7:0] CM1_INDEX = 8'h07;
  localparam logic [7:0] CM3_INDEX = 8'h09;
  localparam logic [7:0] PROTECT_INDEX = 8'h0A;
  localparam logic [7:0] SRC_SEL_INDEX = 8'h0C;
  localparam logic [7:0] CM0_ADDR = CM0_INDEX << 2;
  localparam logic [7:0] CM1_ADDR = CM1_INDEX << 2;
  localparam logic [7:0] CM3_ADDR = CM3_INDEX << 2;
  localparam logic [7:0] PROTECT_ADDR = PROTECT_INDEX << 2;
  localparam logic [7:0] SRC_SEL_ADDR = SRC_SEL_INDEX << 2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned WAIT_STOP_LO_BIT = 1;
  localparam int unsigned WAIT_STOP_HI_BIT = 2;
  localparam int unsigned CRYSTAL_STOP_BIT = 5;
  localparam int unsigned DIV8_SELECT_BIT = 6;
  localparam int unsigned ALL_CLOCK_STOP_BIT = 0;
  localparam int unsigned FEEDBACK_OFF_BIT = 1;
  localparam int unsigned OSC_PIN_ASSIGN_BIT = 3;
  localparam int unsigned LOW_SPEED_OFF_BIT = 4;
  localparam int unsigned CPU_DIV_LO_BIT = 6;
  localparam int unsigned CPU_DIV_HI_BIT = 7;
  localparam int unsigned WAIT_CONTROL_BIT = 0;
  localparam int unsigned NO_DIVISION_BIT = 5;
  localparam int unsigned EXIT_SEL_LO_BIT = 6;
  localparam int unsigned EXIT_SEL_HI_BIT = 7;
  localparam int unsigned CLOCK_WRITE_ENABLE_BIT = 0;
  localparam int unsigned SOURCE_SEL_BIT = 2;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0] CM0_RESET = 8'h20;
  localparam logic [7:0] CM1_RESET = 8'h20;
  localparam logic [7:0] CM3_RESET = 8'h00;
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  localparam logic SOURCE_SEL_RESET = 1'b1;
  localparam logic [7:0] CM3_WRITE_MASK = 8'hFD;
  localparam logic [7:0] PROTECT_WRITE_MASK = 8'h01;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] EXIT_PRIOR_CLOCK = 2'h0;
  localparam logic [1:0] EXIT_CRYSTAL = 2'h3;
  localparam logic [1:0] CPU_DIV_NONE = 2'h0;
  localparam logic [1:0] CPU_DIV_BY2 = 2'h1;
  localparam logic [1:0] CPU_DIV_BY4 = 2'h2;
  localparam logic [1:0] CPU_DIV_BY16 = 2'h3;
  localparam logic [1:0] WAIT_PERIPH_RUN = 2'h0;
  // CPU clock is the system clock divided by two to the power of this code
  localparam logic [2:0] DIV_CODE_1 = 3'h0;
  localparam logic [2:0] DIV_CODE_2 = 3'h1;
  localparam logic [2:0] DIV_CODE_4 = 3'h2;
  localparam logic [2:0] DIV_CODE_8 = 3'h3;
  localparam logic [2:0] DIV_CODE_16 = 3'h4;

  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} cpu_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [2:0] cpu_div_code;
    logic cpu_clock_stop;
    logic periph_div_stop;
    logic all_clocks_stop;
    logic crystal_osc_en;
    logic feedback_res_en;
    logic osc_pins_port;
    logic low_speed_osc_en;
    logic sys_clk_from_osc;
  } clk_out_s;

  typedef struct packed {
    cpu_mode_e mode;
    logic [7:0] cm0;
    logic [7:0] cm1;
    logic [7:0] cm3;
    logic [7:0] protect;
    logic src_sel;
    logic [7:0] rdata;
    clk_out_s outs;
  } ctrl_state_s;

endpackage

/* verilog/cpu_div_decode.sv */
// CPU clock division ratio decoder
`timescale 1ns/1ps

module cpu_div_decode (
  input wire logic div8_select,
  input wire logic [1:0] cpu_div,
  output logic [2:0] div_code
);

  // ****************************************************************
  // Divide-by-8 overrides the two-bit field
  // ****************************************************************
  always_comb begin
    if (div8_select) begin
      div_code = clock_ctrl_pkg::DIV_CODE_8;
    end else begin
      case (cpu_div)
        clock_ctrl_pkg::CPU_DIV_NONE: div_code = clock_ctrl_pkg::DIV_CODE_1;
        clock_ctrl_pkg::CPU_DIV_BY2: div_code = clock_ctrl_pkg::DIV_CODE_2;
        clock_ctrl_pkg::CPU_DIV_BY4: div_code = clock_ctrl_pkg::DIV_CODE_4;
        default: div_code = clock_ctrl_pkg::DIV_CODE_16;
      endcase
    end
  end

endmodule // cpu_div_decode

/* verilog/osc_pin_decode.sv */
// Oscillator, feedback resistor and pin function decoder
`timescale 1ns/1ps

module osc_pin_decode (
  input wire logic crystal_stop,
  input wire logic feedback_resistor_off,
  input wire logic all_clock_stop,
  input wire logic osc_pin_assign,
  input wire logic low_speed_osc_off,
  output logic crystal_osc_en,
  output logic feedback_res_en,
  output logic osc_pins_port,
  output logic low_speed_osc_en
);

  // ****************************************************************
  // Analog enables; stop mode kills the crystal and its resistor
  // ****************************************************************
  assign crystal_osc_en = !crystal_stop && !all_clock_stop;
  assign feedback_res_en = !feedback_resistor_off && !all_clock_stop;
  // Pins are ports only with the crystal stopped and port use chosen
  assign osc_pins_port = crystal_stop && !osc_pin_assign;
  assign low_speed_osc_en = !low_speed_osc_off && !all_clock_stop;

endmodule // osc_pin_decode

/* bench/system_clock_control_regs_tb_top.sv */
// Self-checking bench for the system clock control registers
`timescale 1ns/1ps

module system_clock_control_regs_tb_top;
  logic clk;
  logic sys_rst;
  clock_ctrl_pkg::bus_req_s bus_req;
  logic [7:0] rdata;
  logic wake_irq;
  clock_ctrl_pkg::clk_out_s clk_out;
  int bad_count;
  int n_tests;
  logic [2:0] div_exp [4];

  system_clock_control_regs u_system_clock_control_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .rdata(rdata),
    .wake_irq(wake_irq),
    .clk_out(clk_out)
  );

  // ****************************************************************
  // Clock, checks and bus tasks
  // ****************************************************************
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic results();
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t out got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    chk(rdata, exp);
  endtask

  // Outputs lag the registers by one cycle, mode outputs included
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Wakeup held for exactly one sampling edge
  task automatic wake();
    @(posedge clk);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    settle();
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  // ****************************************************************
  // Watchdog and main sequence
  // ****************************************************************
  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    bus_req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    wake_irq = 1'b0;
    bad_count = 0;
    n_tests = 0;
    div_exp = '{3'h0, 3'h1, 3'h2, 3'h4};
    do_reset();
    settle();
    chkb(clk_out.cpu_div_code, 3'h0);
    chkb({2'h0, clk_out.crystal_osc_en}, 3'h0);
    chkb({2'h0, clk_out.osc_pins_port}, 3'h1);
    chkb({clk_out.feedback_res_en, clk_out.low_speed_osc_en, clk_out.sys_clk_from_osc}, 3'h7);
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h20);
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h20);
    rd(clock_ctrl_pkg::CM3_ADDR, 8'h00);
    rd(clock_ctrl_pkg::SRC_SEL_ADDR, 8'h04);
    rd(8'h00, 8'h00);
    // Protected writes are dropped silently
    wr(clock_ctrl_pkg::CM0_ADDR, 8'h08);
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h24);
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h20);
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h20);
    wr(clock_ctrl_pkg::PROTECT_ADDR, 8'h01);
    // Every division code with the divide-by-8 select clear
    for (int i = 0; i < 4; i++) begin
      wr(clock_ctrl_pkg::CM1_ADDR, {i[1:0], 6'h24});
      settle();
      chkb(clk_out.cpu_div_code, div_exp[i]);
    end
    wr(clock_ctrl_pkg::CM0_ADDR, 8'h48);
    settle();
    chkb(clk_out.cpu_div_code, 3'h3);
    chkb({2'h0, clk_out.crystal_osc_en}, 3'h1);
    chkb({2'h0, clk_out.osc_pins_port}, 3'h0);
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h26);
    settle();
    chkb({2'h0, clk_out.feedback_res_en}, 3'h0);
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h24);
    settle();
    chkb({2'h0, clk_out.feedback_res_en}, 3'h1);
    // Low-speed oscillator off refused while it is the system clock
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h34);
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h24);
    wr(clock_ctrl_pkg::SRC_SEL_ADDR, 8'h00);
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h34);
    settle();
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h34);
    chkb({clk_out.low_speed_osc_en, 1'b0, clk_out.sys_clk_from_osc}, 3'h0);
    // Pin assignment is sticky once set
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h2C);
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h24);
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h2C);
    wr(clock_ctrl_pkg::CM3_ADDR, 8'h02);
    rd(clock_ctrl_pkg::CM3_ADDR, 8'h00);
    // Wait with divided peripheral clocks stopped, then running
    wr(clock_ctrl_pkg::CM0_ADDR, 8'h4A);
    wr(clock_ctrl_pkg::CM3_ADDR, 8'h01);
    settle();
    chkb({clk_out.cpu_clock_stop, clk_out.periph_div_stop, clk_out.crystal_osc_en}, 3'h7);
    rd(clock_ctrl_pkg::CM3_ADDR, 8'h01);
    wake();
    chkb({2'h0, clk_out.cpu_clock_stop}, 3'h0);
    rd(clock_ctrl_pkg::CM3_ADDR, 8'h00);
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h4A);
    wr(clock_ctrl_pkg::CM0_ADDR, 8'h48);
    wr(clock_ctrl_pkg::CM3_ADDR, 8'h01);
    settle();
    chkb({1'b0, clk_out.cpu_clock_stop, clk_out.periph_div_stop}, 3'h2);
    wake();
    // No-division exit forces the divider fields clear at entry
    wr(clock_ctrl_pkg::CM1_ADDR, 8'hEC);
    wr(clock_ctrl_pkg::CM3_ADDR, 8'h21);
    settle();
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h08);
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h2C);
    chkb(clk_out.cpu_div_code, 3'h0);
    wake();
    wr(clock_ctrl_pkg::CM3_ADDR, 8'h00);
    // Stop mode forces divide-by-8 and cuts every oscillator
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h2D);
    settle();
    chkb({clk_out.all_clocks_stop, clk_out.feedback_res_en, clk_out.crystal_osc_en}, 3'h4);
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h48);
    wake();
    chkb({2'h0, clk_out.all_clocks_stop}, 3'h0);
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h2C);
    // Crystal exit starts the crystal and selects it; switch to the oscillator before stopping the crystal
    wr(clock_ctrl_pkg::SRC_SEL_ADDR, 8'h04);
    // Stopped crystal chosen on exit needs divide-by-8 and no-division clear
    wr(clock_ctrl_pkg::CM0_ADDR, 8'h68);
    // The wake pulse stands for an interrupt serviced once the CPU runs again
    wr(clock_ctrl_pkg::CM3_ADDR, 8'hC1);
    settle();
    wake();
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h48);
    rd(clock_ctrl_pkg::SRC_SEL_ADDR, 8'h00);
    rd(clock_ctrl_pkg::CM3_ADDR, 8'hC0);
    chkb({2'h0, clk_out.sys_clk_from_osc}, 3'h0);
    // Mid-run reset restores register 3
    do_reset();
    rd(clock_ctrl_pkg::CM3_ADDR, 8'h00);
    rd(clock_ctrl_pkg::CM0_ADDR, 8'h20);
    // External clock setup: port use, crystal running, resistor off
    wr(clock_ctrl_pkg::PROTECT_ADDR, 8'h01);
    wr(clock_ctrl_pkg::CM1_ADDR, 8'h26);
    wr(clock_ctrl_pkg::CM0_ADDR, 8'h08);
    settle();
    rd(clock_ctrl_pkg::CM1_ADDR, 8'h26);
    chkb({clk_out.crystal_osc_en, clk_out.osc_pins_port, clk_out.feedback_res_en}, 3'h4);
    results();
  end
endmodule // system_clock_control_regs_tb_top
